// File: rtl/mmt_pkg.sv
// Package for the multimode 16-bit timer: register map, fields, modes, state types
`default_nettype none
package mmt_pkg;
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h00;
  localparam logic [7:0] OFF_COUNT_LOW = 8'h04;
  localparam logic [7:0] OFF_RELOAD_HIGH = 8'h08;
  localparam logic [7:0] OFF_RELOAD_LOW = 8'h0c;
  localparam logic [7:0] OFF_PWM_HIGH = 8'h10;
  localparam logic [7:0] OFF_PWM_LOW = 8'h14;
  localparam logic [7:0] OFF_CONTROL = 8'h18;
  localparam logic [7:0] OFF_CONTROL_SECOND = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
  // Control register fields
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_POLARITY_BIT = 6;
  localparam int CTL_PRESCALE_LSB = 3;
  localparam int CTL_MODE_LSB = 0;
  // Second control register: capture mode interrupt source select field
  localparam int CTL2_SRC_LSB = 0;
  localparam logic [1:0] SRC_BOTH = 2'h0;
  localparam logic [1:0] SRC_CAPTURE = 2'h1;
  localparam logic [1:0] SRC_RELOAD = 2'h2;
  // Interrupt status bits
  localparam int IRQ_TIMER_BIT = 0;
  localparam int IRQ_CAPTURE_BIT = 1;
  localparam int IRQ_RELOAD_BIT = 2;
  // Reset values and count constants
  localparam logic [15:0] RST_COUNT = 16'h0001;
  localparam logic [15:0] RST_RELOAD = 16'hffff;
  localparam logic [15:0] RST_PWM = 16'h0000;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // Operating modes, as encoded in the control register mode field
  localparam logic [2:0] MODE_ONE_SHOT = 3'h0;
  localparam logic [2:0] MODE_CONTINUOUS = 3'h1;
  localparam logic [2:0] MODE_COUNTER = 3'h2;
  localparam logic [2:0] MODE_PWM_SINGLE = 3'h3;
  localparam logic [2:0] MODE_CAPTURE = 3'h4;
  localparam logic [2:0] MODE_COMPARE = 3'h5;
  localparam logic [2:0] MODE_GATED = 3'h6;
  localparam logic [2:0] MODE_CAPTURE_COMPARE = 3'h7;
  localparam logic [2:0] STATUS_WIDTH = 3'h3;

  typedef enum logic [0:0] {MMT_IDLE, MMT_ACK} mmt_bus_state_type;
  typedef enum logic [0:0] {MMT_WAIT_EDGE, MMT_RUN} mmt_run_state_type;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
    logic [15:0] pwm;
    logic [7:0] control;
    logic [7:0] control_second;
    logic [7:0] hold_low;
    logic [2:0] status;
    logic [2:0] mask;
    logic [7:0] prescale_count;
    logic timer_out;
    logic in_meta;
    logic in_sync;
    logic in_prev;
    logic [31:0] rd_data;
    mmt_bus_state_type bus_state;
    mmt_run_state_type run_state;
  } mmt_state_type;
endpackage : mmt_pkg
`default_nettype wire

// File: rtl/mmt_timer.sv
// Multimode 16-bit timer with classic Wishbone register slave
`default_nettype none

module mmt_timer
  import mmt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic timer_in_i,
  input wire logic dual_pwm_i,
  output logic timer_out_o,
  output logic irq_o
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] inc16(input logic [15:0] v);
    inc16 = v + COUNT_ONE;
  endfunction : inc16

  mmt_state_type st;
  mmt_state_type next_st;

  logic enabled;
  logic pol;
  logic [2:0] mode;
  logic [2:0] presc_sel;
  logic [7:0] presc_last;
  logic tick;
  logic rise;
  logic fall;
  logic act_edge;
  logic pin_in;
  logic advance;
  logic reload_hit;
  logic do_capture;
  logic gate_int;
  logic wr_acc;
  logic rd_acc;
  logic [2:0] events;
  logic [1:0] src;

  assign enabled = st.control[CTL_ENABLE_BIT];
  assign pol = st.control[CTL_POLARITY_BIT];
  assign mode = st.control[CTL_MODE_LSB +: 3];
  assign presc_sel = st.control[CTL_PRESCALE_LSB +: 3];
  assign src = st.control_second[CTL2_SRC_LSB +: 2];
  assign presc_last = 8'((9'h001 << presc_sel) - 9'h001);
  // ****************************************
  // Input edge detection
  // ****************************************
  // No input in dual PWM output mode; hold the idle polarity level
  assign pin_in = dual_pwm_i ? pol : st.in_sync;
  assign rise = pin_in & ~st.in_prev;
  assign fall = ~pin_in & st.in_prev;
  assign act_edge = pol ? fall : rise;
  assign tick = (st.prescale_count == presc_last);

  assign wr_acc = cyc_i & stb_i & we_i & (st.bus_state == MMT_IDLE);
  assign rd_acc = cyc_i & stb_i & ~we_i & (st.bus_state == MMT_IDLE);

  always_comb
  begin
    next_st = st;
    advance = 1'b0;
    do_capture = 1'b0;
    gate_int = 1'b0;
    events = '0;
    next_st.in_meta = timer_in_i;
    next_st.in_sync = st.in_meta;
    next_st.in_prev = pin_in;
    // ****************************************
    // Counting
    // ****************************************
    if (enabled)
    begin
      next_st.prescale_count = tick ? 8'h00 : st.prescale_count + 8'h01;
      case (mode)
        MODE_COUNTER:
          advance = act_edge;
        MODE_GATED:
        begin
          advance = tick & (pin_in ^ pol);
          gate_int = pol ? rise : fall;
        end
        MODE_CAPTURE:
        begin
          advance = tick;
          do_capture = act_edge;
        end
        MODE_CAPTURE_COMPARE:
          if (st.run_state == MMT_WAIT_EDGE)
          begin
            // First edge only starts the count
            if (act_edge)
              next_st.run_state = MMT_RUN;
          end
          else
          begin
            advance = tick;
            do_capture = act_edge;
          end
        default:
          advance = tick;
      endcase
    end
    else
    begin
      next_st.prescale_count = 8'h00;
      next_st.run_state = MMT_WAIT_EDGE;
    end
    reload_hit = advance & (st.count == st.reload);
    if (advance)
    begin
      if (reload_hit && mode == MODE_COMPARE)
        next_st.count = inc16(st.count);
      else if (reload_hit)
        next_st.count = COUNT_ONE;
      else
        next_st.count = inc16(st.count);
    end
    if (do_capture)
    begin
      next_st.pwm = st.count;
      if (mode == MODE_CAPTURE_COMPARE)
        next_st.count = COUNT_ONE;
    end
    // ****************************************
    // Output pin
    // ****************************************
    if (!enabled)
      next_st.timer_out = pol;
    else if (mode == MODE_PWM_SINGLE)
    begin
      if (reload_hit)
        next_st.timer_out = pol;
      else if (advance && st.count == st.pwm)
        next_st.timer_out = ~pol;
    end
    else if (reload_hit)
      next_st.timer_out = ~st.timer_out;
    // ****************************************
    // Events
    // ****************************************
    events[IRQ_CAPTURE_BIT] = do_capture;
    events[IRQ_RELOAD_BIT] = reload_hit;
    if (mode == MODE_CAPTURE)
      events[IRQ_TIMER_BIT] = (src != SRC_RELOAD && do_capture)
        || (src != SRC_CAPTURE && reload_hit);
    else
      events[IRQ_TIMER_BIT] = reload_hit | do_capture | gate_int;
    // ****************************************
    // Register bus
    // ****************************************
    next_st.bus_state = MMT_IDLE;
    if (rd_acc || wr_acc)
      next_st.bus_state = MMT_ACK;
    next_st.rd_data = '0;
    if (wr_acc && sel_i[0])
      case (adr_i)
        OFF_COUNT_HIGH: next_st.count[15:8] = dat_i[7:0];
        OFF_COUNT_LOW: next_st.count[7:0] = dat_i[7:0];
        OFF_RELOAD_HIGH: next_st.reload[15:8] = dat_i[7:0];
        OFF_RELOAD_LOW: next_st.reload[7:0] = dat_i[7:0];
        OFF_PWM_HIGH: next_st.pwm[15:8] = dat_i[7:0];
        OFF_PWM_LOW: next_st.pwm[7:0] = dat_i[7:0];
        OFF_CONTROL: next_st.control = dat_i[7:0];
        OFF_CONTROL_SECOND: next_st.control_second = dat_i[7:0];
        OFF_IRQ_MASK: next_st.mask = dat_i[2:0];
        default: ;
      endcase
    // Sticky status; a new event wins over the read clear
    if (rd_acc && adr_i == OFF_IRQ_STATUS)
      next_st.status = events;
    else
      next_st.status = st.status | events;
    if (rd_acc)
      case (adr_i)
        OFF_COUNT_HIGH:
        begin
          next_st.rd_data[7:0] = st.count[15:8];
          if (enabled)
            next_st.hold_low = st.count[7:0];
        end
        OFF_COUNT_LOW:
          next_st.rd_data[7:0] = enabled ? st.hold_low : st.count[7:0];
        OFF_RELOAD_HIGH: next_st.rd_data[7:0] = st.reload[15:8];
        OFF_RELOAD_LOW: next_st.rd_data[7:0] = st.reload[7:0];
        OFF_PWM_HIGH: next_st.rd_data[7:0] = st.pwm[15:8];
        OFF_PWM_LOW: next_st.rd_data[7:0] = st.pwm[7:0];
        OFF_CONTROL: next_st.rd_data[7:0] = st.control;
        OFF_CONTROL_SECOND: next_st.rd_data[7:0] = st.control_second;
        OFF_IRQ_STATUS: next_st.rd_data[2:0] = st.status;
        OFF_IRQ_MASK: next_st.rd_data[2:0] = st.mask;
        default: next_st.rd_data = '0;
      endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.count <= RST_COUNT;
      st.reload <= RST_RELOAD;
      st.pwm <= RST_PWM;
      st.control <= RST_CONTROL;
      st.bus_state <= MMT_IDLE;
      st.run_state <= MMT_WAIT_EDGE;
    end
    else if (ce_i)
      st <= next_st;
  end

  assign ack_o = (st.bus_state == MMT_ACK) & cyc_i & stb_i;
  assign dat_o = st.rd_data;
  assign timer_out_o = st.timer_out;
  assign irq_o = |(st.status & st.mask);

  // ****************************************
  // Checks
  // ****************************************
  AST_COMPARE_NO_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_COMPARE && reload_hit && st.count != COUNT_MAX
    && !(wr_acc && sel_i[0]) |=> st.count == $past(st.count) + 16'h0001)
    else $error("Compare match restarted count");
  AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && advance && !do_capture && st.count == COUNT_MAX && !reload_hit
    && !(wr_acc && sel_i[0]) |=> st.count == 16'h0000)
    else $error("Count did not wrap to zero");
  AST_TOGGLE_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode != MODE_PWM_SINGLE && reload_hit
    && !(wr_acc && adr_i == OFF_CONTROL) |=> timer_out_o != $past(timer_out_o))
    else $error("Output did not toggle on reload");
  AST_IDLE_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !enabled ##1 !enabled |-> timer_out_o == $past(pol))
    else $error("Disabled output not at polarity");
  AST_FIRST_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_CAPTURE_COMPARE && st.run_state == MMT_WAIT_EDGE
    |=> !$past(events[IRQ_CAPTURE_BIT]))
    else $error("First edge raised a capture");
  AST_CAPTURE_PWM: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && do_capture |=> st.pwm == $past(st.count))
    else $error("Capture not loaded into PWM registers");
  AST_HOLD_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_acc && enabled && adr_i == OFF_COUNT_HIGH |=> st.hold_low == $past(st.count[7:0]))
    else $error("Low byte not held");
  AST_LIVE_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_acc && !enabled && adr_i == OFF_COUNT_LOW |=> dat_o[7:0] == $past(st.count[7:0]))
    else $error("Disabled low read not live");
  AST_CAPTURE_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mode == MODE_CAPTURE && src == SRC_CAPTURE && reload_hit && !do_capture
    |-> !events[IRQ_TIMER_BIT])
    else $error("Reload interrupt in capture-only setting");
  // ****************************************
  // Mode, clock enable, bus and status checks
  // ****************************************
  AST_COMPARE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_COMPARE && !tick && !(wr_acc && sel_i[0])
    |=> st.count == $past(st.count))
    else $error("Count moved between prescaler ticks");
  AST_COMPARE_CLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_COMPARE |-> advance == tick)
    else $error("Compare mode not clocked by prescaler");
  AST_COMPARE_TOGGLE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_COMPARE && reload_hit
    && !(wr_acc && adr_i == OFF_CONTROL) |=> timer_out_o != $past(timer_out_o))
    else $error("Compare match did not toggle output");
  AST_COMPARE_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_COMPARE && reload_hit |=> st.status[IRQ_TIMER_BIT])
    else $error("Compare match raised no interrupt");
  AST_CAPCMP_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_CAPTURE_COMPARE && st.run_state == MMT_WAIT_EDGE
    |-> !events[IRQ_TIMER_BIT])
    else $error("Interrupt before counting started");
  AST_CAPCMP_START: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_CAPTURE_COMPARE && st.run_state == MMT_WAIT_EDGE
    && act_edge && !(wr_acc && adr_i == OFF_CONTROL) |=> st.run_state == MMT_RUN)
    else $error("First edge did not start counting");
  AST_RELOAD_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mode == MODE_CAPTURE && src == SRC_RELOAD && do_capture && !reload_hit
    |-> !events[IRQ_TIMER_BIT])
    else $error("Capture interrupt in reload-only setting");
  AST_BOTH_SRC: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mode == MODE_CAPTURE && src == SRC_BOTH && (do_capture || reload_hit)
    |-> events[IRQ_TIMER_BIT])
    else $error("Default source missed an event");
  AST_RELOAD_NO_PWM: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && reload_hit && !do_capture
    && !(wr_acc && (adr_i == OFF_PWM_HIGH || adr_i == OFF_PWM_LOW))
    |=> st.pwm == $past(st.pwm))
    else $error("Reload disturbed PWM registers");
  AST_COUNTER_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_COUNTER |-> advance == act_edge)
    else $error("Counter mode advanced off the selected edge");
  AST_COUNTER_POL: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_COUNTER && !pol && fall |-> !advance)
    else $error("Rising-edge counter took a falling edge");
  AST_PWM_MATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_PWM_SINGLE && advance && st.count == st.pwm
    && !reload_hit && !(wr_acc && adr_i == OFF_CONTROL) |=> timer_out_o == !$past(pol))
    else $error("PWM match level wrong");
  AST_PWM_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_PWM_SINGLE && reload_hit
    && !(wr_acc && adr_i == OFF_CONTROL) |=> timer_out_o == $past(pol))
    else $error("PWM reload level wrong");
  AST_CAPTURE_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_CAPTURE |-> do_capture == act_edge)
    else $error("Capture off the selected edge");
  AST_GATED_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_GATED && pin_in == pol |-> !advance)
    else $error("Gated count ran while gate closed");
  AST_GATED_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enabled && mode == MODE_GATED && (pol ? rise : fall) |-> events[IRQ_TIMER_BIT])
    else $error("Gate close raised no interrupt");
  AST_DUAL_NO_INPUT: assert property (@(posedge clk_i) disable iff (rst_i)
    dual_pwm_i && $past(dual_pwm_i) && $past(ce_i) && $stable(pol) |-> !rise && !fall)
    else $error("Input edge seen in dual PWM mode");
  AST_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(st))
    else $error("State moved with clock enable low");
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ack_o |=> !ack_o)
    else $error("Acknowledge longer than one cycle");
  AST_READ_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_acc && adr_i == OFF_IRQ_STATUS && events == 3'h0 |=> st.status == 3'h0)
    else $error("Status read did not clear");
  AST_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && events[IRQ_TIMER_BIT] |=> st.status[IRQ_TIMER_BIT])
    else $error("Timer event not recorded");
  AST_CAPTURE_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mode == MODE_CAPTURE && src == SRC_CAPTURE && do_capture
    |-> events[IRQ_TIMER_BIT])
    else $error("Capture-only setting missed a capture");
endmodule : mmt_timer
`default_nettype wire

// File: sim/mmt_pin_source.sv
// Signal source that drives the timer input pin
`default_nettype none
module mmt_pin_source (
  input wire logic clk_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin_o = 1'b0;
  // Edges spaced well past the two-stage input synchroniser
  task automatic drive(input logic lvl);
    @(posedge clk_i);
    pin_o <= lvl;
    repeat (6) @(posedge clk_i);
  endtask : drive
endmodule : mmt_pin_source
`default_nettype wire

// File: sim/mmt_timer_bench.sv
// Self-checking bench for the multimode timer
`default_nettype none
module mmt_timer_bench;
  import mmt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, dual_pwm_i, pin;
  logic [7:0] adr_i;
  logic [7:0] q;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic ack_o, timer_out_o, irq_o, pol;
  logic [15:0] v, w;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  mmt_timer uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .timer_in_i(pin), .dual_pwm_i(dual_pwm_i), .timer_out_o(timer_out_o), .irq_o(irq_o));
  mmt_pin_source src (.clk_i(clk_i), .pin_o(pin));
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // *************************
  // Tasks
  // *************************
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Holds the request until ack is sampled or 40 further edges pass; no latency assumed
  task automatic wb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    k = 0;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && k < 40)
    begin
      @(posedge clk_i);
      k++;
    end
    chk("ack", {15'h0000, ack_o}, 16'h0001);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, d[15:8]);
    wb(1'b1, a + 8'h04, d[7:0]);
  endtask : wr16
  task automatic rd16(input logic [7:0] a);
    wb(1'b0, a, 8'h00);
    v[15:8] = q;
    wb(1'b0, a + 8'h04, 8'h00);
    v[7:0] = q;
  endtask : rd16
  task automatic ctl(input logic en, input logic p, input logic [2:0] pre, input logic [2:0] m);
    wb(1'b1, OFF_CONTROL, {en, p, pre, m});
  endtask : ctl
  // Bounded wait for the output pin to reach a level
  task automatic wait_out(input logic lvl);
    int k;
    k = 0;
    while (timer_out_o !== lvl && k < 300)
    begin
      @(posedge clk_i);
      k++;
    end
    chk("out level", {15'h0000, timer_out_o}, {15'h0000, lvl});
  endtask : wait_out
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      chk("timeout", 16'h0001, 16'h0000);
      test_done();
    end
  end
  // *************************
  // Tests
  // *************************
  initial
  begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    {cyc_i, stb_i, we_i, dual_pwm_i} = 4'h0;
    adr_i = 8'h00;
    sel_i = 4'h1;
    dat_i = 32'h00000000;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd16(OFF_COUNT_HIGH);
    chk("count rst", v, RST_COUNT);
    rd16(OFF_RELOAD_HIGH);
    chk("reload rst", v, RST_RELOAD);
    wb(1'b0, 8'hfc, 8'h00);
    chk("unmapped", {8'h00, q}, 16'h0000);
    $display("test reset done");
    ctl(1'b0, 1'b0, 3'h7, MODE_COMPARE);
    wr16(OFF_COUNT_HIGH, 16'hfffe);
    wr16(OFF_RELOAD_HIGH, 16'h0003);
    wb(1'b1, OFF_IRQ_MASK, 8'h01);
    ctl(1'b1, 1'b0, 3'h7, MODE_COMPARE);
    n = 0;
    while (irq_o !== 1'b1 && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("match time", {15'h0000, n > 500 && n < 800}, 16'h0001);
    chk("out toggle", {15'h0000, timer_out_o}, 16'h0001);
    rd16(OFF_COUNT_HIGH);
    chk("count kept", {15'h0000, v == 16'h0003 || v == 16'h0004}, 16'h0001);
    // Fast count so a live low byte would differ between reads
    ctl(1'b1, 1'b0, 3'h0, MODE_COMPARE);
    wb(1'b0, OFF_COUNT_HIGH, 8'h00);
    repeat (9) @(posedge clk_i);
    wb(1'b0, OFF_COUNT_LOW, 8'h00);
    w[7:0] = q;
    repeat (9) @(posedge clk_i);
    wb(1'b0, OFF_COUNT_LOW, 8'h00);
    chk("held low", {8'h00, q}, {8'h00, w[7:0]});
    // Clock enable low must stop the count
    ctl(1'b0, 1'b0, 3'h0, MODE_COMPARE);
    wr16(OFF_COUNT_HIGH, 16'h0000);
    ctl(1'b1, 1'b0, 3'h0, MODE_COMPARE);
    ce_i <= 1'b0;
    repeat (100) @(posedge clk_i);
    ce_i <= 1'b1;
    ctl(1'b0, 1'b0, 3'h0, MODE_COMPARE);
    rd16(OFF_COUNT_HIGH);
    chk("frozen", {15'h0000, v < 16'h0010}, 16'h0001);
    wb(1'b1, OFF_IRQ_MASK, 8'h00);
    chk("irq masked", {15'h0000, irq_o}, 16'h0000);
    wb(1'b0, OFF_IRQ_STATUS, 8'h00);
    chk("status", {15'h0000, q[IRQ_TIMER_BIT]}, 16'h0001);
    wb(1'b0, OFF_IRQ_STATUS, 8'h00);
    chk("status clr", {8'h00, q}, 16'h0000);
    $display("test compare done");
    for (int p = 0; p < 3; p++)
    begin
      pol = (p == 1);
      ctl(1'b0, pol, 3'h0, MODE_COUNTER);
      // Output register follows the control write one edge later
      @(posedge clk_i);
      chk("out idle", {15'h0000, timer_out_o}, {15'h0000, pol});
      dual_pwm_i <= (p == 2);
      src.drive(1'b0);
      wr16(OFF_COUNT_HIGH, 16'h0000);
      ctl(1'b1, pol, 3'h0, MODE_COUNTER);
      for (int e = 0; e < 5; e++)
        src.drive(~e[0]);
      ctl(1'b0, pol, 3'h0, MODE_COUNTER);
      rd16(OFF_COUNT_HIGH);
      chk("edges", v, (p == 2) ? 16'h0000 : (pol ? 16'h0002 : 16'h0003));
    end
    dual_pwm_i <= 1'b0;
    $display("test counter done");
    ctl(1'b0, 1'b1, 3'h0, MODE_CAPTURE);
    wr16(OFF_PWM_HIGH, 16'h0000);
    wb(1'b1, OFF_CONTROL_SECOND, {6'h00, SRC_CAPTURE});
    wb(1'b1, OFF_IRQ_MASK, 8'h01);
    ctl(1'b1, 1'b1, 3'h0, MODE_CAPTURE);
    src.drive(1'b0);
    rd16(OFF_PWM_HIGH);
    chk("captured", {15'h0000, v != 16'h0000}, 16'h0001);
    chk("irq cap", {15'h0000, irq_o}, 16'h0001);
    wr16(OFF_PWM_HIGH, 16'h0000);
    src.drive(1'b1);
    rd16(OFF_PWM_HIGH);
    chk("no rise cap", v, 16'h0000);
    $display("test capture done");
    ctl(1'b0, 1'b0, 3'h0, MODE_CAPTURE_COMPARE);
    wr16(OFF_RELOAD_HIGH, 16'hffff);
    wr16(OFF_COUNT_HIGH, 16'h0000);
    wr16(OFF_PWM_HIGH, 16'h0000);
    wb(1'b0, OFF_IRQ_STATUS, 8'h00);
    ctl(1'b1, 1'b0, 3'h0, MODE_CAPTURE_COMPARE);
    src.drive(1'b0);
    src.drive(1'b1);
    chk("first edge irq", {15'h0000, irq_o}, 16'h0000);
    src.drive(1'b0);
    src.drive(1'b1);
    chk("capcmp irq", {15'h0000, irq_o}, 16'h0001);
    rd16(OFF_PWM_HIGH);
    chk("capcmp value", {15'h0000, v != 16'h0000}, 16'h0001);
    $display("test capture compare done");
    for (int p = 0; p < 2; p++)
    begin
      pol = p[0];
      ctl(1'b0, pol, 3'h0, MODE_PWM_SINGLE);
      wr16(OFF_COUNT_HIGH, 16'h0001);
      wr16(OFF_RELOAD_HIGH, 16'h0040);
      wr16(OFF_PWM_HIGH, 16'h0020);
      @(posedge clk_i);
      chk("pwm idle", {15'h0000, timer_out_o}, {15'h0000, pol});
      ctl(1'b1, pol, 3'h0, MODE_PWM_SINGLE);
      wait_out(~pol);
      wait_out(pol);
    end
    $display("test pwm done");
    ctl(1'b0, 1'b0, 3'h0, MODE_GATED);
    wr16(OFF_COUNT_HIGH, 16'h0000);
    wb(1'b0, OFF_IRQ_STATUS, 8'h00);
    ctl(1'b1, 1'b0, 3'h0, MODE_GATED);
    src.drive(1'b0);
    chk("gate irq", {15'h0000, irq_o}, 16'h0001);
    rd16(OFF_COUNT_HIGH);
    w = v;
    repeat (20) @(posedge clk_i);
    rd16(OFF_COUNT_HIGH);
    chk("gate hold", v, w);
    $display("test gated done");
    test_done();
  end
endmodule : mmt_timer_bench
`default_nettype wire
